// *** hdl/flash_seq.sv ***
/*
  Burst latency control and embedded erase sequencer of a burst NOR flash.
  Assumes the command interpreter presents decoded write cycles on WR_*
  and the burst engine requests latency via BURST_START and BURST_ADVANCE.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - The two-bit wait field from the upper address bits gives counts 0..3, total initial latency is that count plus four.
// - An embedded erase first programs every word of the region to zero and then erases it.
// - A burst that crosses an address boundary gets three extra clocks of latency at any frequency.
// - In unlock bypass mode chip erase is accepted as a two-write sequence.
// - A small sector erase takes typically 0.3 s and at most 5 s, excluding preprogramming.
// - Whole-array programming without acceleration takes typically 48 s and at most 144 s.
// - Whole-array programming with acceleration takes typically 16 s and at most 48 s.
// - On a 64-word boundary the device inserts latency and holds ready low during it.
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int REGION_WORDS = 4096,
  parameter longint ERASE_CYCLES = SMALL_ERASE_CYC,
  parameter int PROG_CYCLES = WORD_PROG_CYC,
  parameter int PROG_ACC_CYCLES = WORD_PROG_ACC_CYC
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic WR_STROBE,
  input wire logic [ADDR_W-1:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic BURST_START,
  input wire logic BURST_ADVANCE,
  input wire logic [ADDR_W-1:0] BURST_ADDR,
  input wire logic ACCEL_PIN,
  output logic READY,
  output logic BUSY,
  output logic DONE_PULSE,
  output logic [ADDR_W-1:0] ARRAY_ADDR,
  output logic [DATA_W-1:0] ARRAY_DATA,
  output logic ARRAY_WRITE
);

  // Operation and command states
  typedef enum {S_IDLE, S_PREPROG, S_ERASE, S_DONE} op_state_type;
  typedef enum {C_IDLE, C_U1, C_U2, C_SETUP, C_SU1, C_SU2, C_BYPASS, C_BSETUP} cmd_state_type;

  // Boundary test used by the advance path, in both the counter and ready
  // Only the low address bits matter; the block size is a power of two
  function automatic logic at_boundary(input logic [ADDR_W-1:0] a);
    return a[BOUNDARY_BITS-1:0] == '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Acceleration pin synchroniser, three stages, change on agreement
  // The supply pin is asynchronous; two agreeing stages filter one bad sample
  logic acc_s1_r, acc_s2_r, acc_s3_r, acc_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      acc_s1_r <= 1'b0;
      acc_s2_r <= 1'b0;
      acc_s3_r <= 1'b0;
      acc_r <= 1'b0;
    end else begin
      acc_s1_r <= ACCEL_PIN;
      acc_s2_r <= acc_s1_r;
      acc_s3_r <= acc_s2_r;
      // Otherwise the last agreed level is held
      if (acc_s2_r == acc_s3_r) begin
        acc_r <= acc_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait field capture; kept until rewritten or reset
  // Only the config code latches, so a stray write leaves burst timing alone
  logic [WAIT_FIELD_W-1:0] wait_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wait_r <= '0;
    end else if (WR_STROBE && WR_DATA == CMD_CONFIG) begin
      wait_r <= WR_ADDR[WAIT_FIELD_LSB +: WAIT_FIELD_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency counter: ready stays low while it runs
  logic [3:0] lat_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      lat_r <= '0;
    end else if (BURST_START) begin
      // The start cycle itself is the first low clock, so the counter owes one less
      lat_r <= 4'(BASE_LATENCY - 1) + 4'(wait_r);
    end else if (BURST_ADVANCE && lat_r == '0 && at_boundary(BURST_ADDR)) begin
      lat_r <= 4'(BOUNDARY_EXTRA);
    end else if (lat_r != '0) begin
      lat_r <= lat_r - 4'd1;
    end
  end
  // Boundary stall shows on ready in the same cycle as the crossing
  // Limitation: a boundary hit while latency is still owed is not stretched
  // further; the pending count already covers it
  assign READY = (lat_r == '0) && !(BURST_ADVANCE && at_boundary(BURST_ADDR)) && !BURST_START;

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder: normal six-write erase or two-write bypass erase
  cmd_state_type cmd_r;
  logic erase_go;
  // Erase start is decoded combinationally so busy rises on the very next edge
  always_comb begin
    erase_go = 1'b0;
    if (WR_STROBE && WR_DATA == CMD_CHIP_ERASE) begin
      erase_go = (cmd_r == C_SU2) || (cmd_r == C_BSETUP);
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cmd_r <= C_IDLE;
    end else if (WR_STROBE) begin
      // Normal path: two unlocks, setup, two unlocks, then the erase code
      // Bypass stays entered after an erase; only the exit code leaves it
      unique case (cmd_r)
        C_IDLE: cmd_r <= (WR_DATA == CMD_UNLOCK1) ? C_U1 : C_IDLE;
        C_U1: cmd_r <= (WR_DATA == CMD_UNLOCK2) ? C_U2 : C_IDLE;
        C_U2: begin
          if (WR_DATA == CMD_ERASE_SETUP) begin
            cmd_r <= C_SETUP;
          end else if (WR_DATA == CMD_BYPASS_ENTER) begin
            cmd_r <= C_BYPASS;
          end else begin
            cmd_r <= C_IDLE;
          end
        end
        C_SETUP: cmd_r <= (WR_DATA == CMD_UNLOCK1) ? C_SU1 : C_IDLE;
        C_SU1: cmd_r <= (WR_DATA == CMD_UNLOCK2) ? C_SU2 : C_IDLE;
        C_SU2: cmd_r <= C_IDLE;
        C_BYPASS: begin
          if (WR_DATA == CMD_ERASE_SETUP) begin
            cmd_r <= C_BSETUP;
          end else if (WR_DATA == CMD_BYPASS_EXIT1) begin
            cmd_r <= C_IDLE;
          end else begin
            cmd_r <= C_BYPASS;
          end
        end
        C_BSETUP: cmd_r <= C_BYPASS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Embedded erase: zero every word, then erase, busy throughout
  // 64-bit timer: the real erase figure runs to tens of millions of cycles
  // Trade-off: the typical erase time is used; the worst case is the caller's timeout
  op_state_type op_r;
  logic [ADDR_W-1:0] word_r;
  logic [63:0] tmr_r;
  logic [63:0] prog_len;
  assign prog_len = acc_r ? 64'(PROG_ACC_CYCLES) : 64'(PROG_CYCLES);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      op_r <= S_IDLE;
      word_r <= '0;
      tmr_r <= '0;
    end else begin
      unique case (op_r)
        S_IDLE: if (erase_go) begin
          op_r <= S_PREPROG;
          word_r <= '0;
          tmr_r <= '0;
        end
        S_PREPROG: begin
          // Each word gets a full program slot; its strobe goes out at slot start
          if (tmr_r + 64'd1 >= prog_len) begin
            tmr_r <= '0;
            if (word_r == ADDR_W'(REGION_WORDS - 1)) begin
              op_r <= S_ERASE;
              word_r <= '0;
            end else begin
              word_r <= word_r + 1'b1;
            end
          end else begin
            tmr_r <= tmr_r + 64'd1;
          end
        end
        S_ERASE: begin
          if (tmr_r + 64'd1 >= 64'(ERASE_CYCLES)) begin
            op_r <= S_DONE;
          end else begin
            tmr_r <= tmr_r + 64'd1;
          end
        end
        // One state between erases lets the done pulse rise in the cycle busy falls
        S_DONE: op_r <= S_IDLE;
      endcase
    end
  end

  // Array write strobes: one per word in the preprogram phase only
  // Address and data are registered every cycle; only the strobe says when they count
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ARRAY_WRITE <= 1'b0;
      ARRAY_ADDR <= '0;
      ARRAY_DATA <= '0;
      BUSY <= 1'b0;
      DONE_PULSE <= 1'b0;
    end else begin
      ARRAY_WRITE <= (op_r == S_PREPROG) && (tmr_r == '0);
      ARRAY_ADDR <= word_r;
      ARRAY_DATA <= (op_r == S_ERASE) ? ERASED_WORD : ZERO_WORD;
      // An erase code written while an erase still runs is dropped, so busy must not echo it
      BUSY <= (erase_go && op_r == S_IDLE) || op_r == S_PREPROG || op_r == S_ERASE;
      DONE_PULSE <= (op_r == S_DONE);
    end
  end

endmodule
`default_nettype wire

// *** hdl/flash_seq_pkg.sv ***
/*
  Constants shared by the flash sequencer: latency figures, boundary
  geometry, command codes and embedded-operation timing.
  Assumes a 200 MHz MCLK; long times are scaled by module parameters.
*/
package flash_seq_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_NS = 5;
  localparam int WAIT_FIELD_LSB = 12;
  localparam int WAIT_FIELD_W = 2;
  localparam int BASE_LATENCY = 4;
  localparam int BOUNDARY_EXTRA = 2;
  localparam int BOUNDARY_WORDS = 64;
  localparam int BOUNDARY_BITS = $clog2(BOUNDARY_WORDS);
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BYPASS_ENTER = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_CONFIG = 8'hc0;
  // Erase-phase timing in microseconds, typical and worst for a small sector
  localparam int SMALL_ERASE_TYP_US = 300000;
  localparam int SMALL_ERASE_MAX_US = 5000000;
  // Whole-array programming figures in seconds
  localparam int CHIP_PROG_TYP_S = 48;
  localparam int CHIP_PROG_MAX_S = 144;
  localparam int CHIP_PROG_ACC_TYP_S = 16;
  localparam int CHIP_PROG_ACC_MAX_S = 48;
  localparam int WORD_PROG_TYP_NS = 11500;
  localparam int WORD_PROG_ACC_TYP_NS = 4000;
  localparam int WORD_PROG_CYC = (WORD_PROG_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WORD_PROG_ACC_CYC = (WORD_PROG_ACC_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam longint SMALL_ERASE_CYC = longint'(SMALL_ERASE_TYP_US) * CLK_MHZ;
endpackage

// *** dv/flash_seq_monitor.sv ***
/* Checker for flash_seq latency and erase outputs.
   Sees the top ports only; bound at the foot. */
`timescale 1ns/10ps
`default_nettype none
module flash_seq_monitor
  import flash_seq_pkg::*;
#(parameter longint ERASE_CYCLES = 10) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic WR_STROBE,
  input wire logic [ADDR_W-1:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic BURST_START,
  input wire logic BURST_ADVANCE,
  input wire logic [ADDR_W-1:0] BURST_ADDR,
  input wire logic READY,
  input wire logic BUSY,
  input wire logic DONE_PULSE,
  input wire logic [DATA_W-1:0] ARRAY_DATA,
  input wire logic ARRAY_WRITE
);
  logic [1:0] wait_r;
  logic [3:0] pend_r;
  longint gap_r;
  wire logic bnd = BURST_ADVANCE && !BURST_START && BURST_ADDR[5:0] == 6'h00 && pend_r == 4'h0;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////
  // Shadow of the wait field and of the low cycles still owed
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wait_r <= 2'h0;
      pend_r <= 4'h0;
    end else begin
      if (WR_STROBE && WR_DATA == CMD_CONFIG) wait_r <= WR_ADDR[13:12];
      if (BURST_START) pend_r <= 4'h3 + 4'(wait_r);
      else if (bnd) pend_r <= 4'h2;
      else if (pend_r != 4'h0) pend_r <= pend_r - 4'h1;
    end
  end
  // Age of the last preprogram write, so the erase phase can be timed
  always_ff @(posedge MCLK) begin
    if (SRST || ARRAY_WRITE) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end
  ////////////////////////////////
  property p_start_low; BURST_START |-> !READY; endproperty
  a_start_low: assert property (p_start_low) else $error("ready high at start");
  property p_pend_low; pend_r != 4'h0 |-> !READY; endproperty
  a_pend_low: assert property (p_pend_low) else $error("ready high in latency");
  property p_pend_end; pend_r == 4'h1 |=> READY || BURST_START || BURST_ADVANCE; endproperty
  a_pend_end: assert property (p_pend_end) else $error("latency too long");
  property p_bnd; bnd |-> !READY ##1 !READY ##1 !READY; endproperty
  a_bnd: assert property (p_bnd) else $error("boundary latency short");
  property p_plain; BURST_ADVANCE && !BURST_START && BURST_ADDR[5:0] != 6'h00 && pend_r == 4'h0 |-> READY; endproperty
  a_plain: assert property (p_plain) else $error("latency off boundary");
  property p_done; DONE_PULSE |-> !BUSY && $past(BUSY) ##1 !DONE_PULSE; endproperty
  a_done: assert property (p_done) else $error("done without busy end");
  property p_zero; ARRAY_WRITE |-> BUSY && ARRAY_DATA == ZERO_WORD; endproperty
  a_zero: assert property (p_zero) else $error("preprogram word not zero");
  property p_gap; DONE_PULSE |-> gap_r >= ERASE_CYCLES - 1; endproperty
  a_gap: assert property (p_gap) else $error("erase phase too short");
  c_bnd: cover property (bnd);
  c_done: cover property (DONE_PULSE);
  c_wait3: cover property (BURST_START && wait_r == 2'h3);
endmodule
bind flash_seq flash_seq_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) mon (.MCLK(MCLK), .SRST(SRST),
  .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .BURST_START(BURST_START),
  .BURST_ADVANCE(BURST_ADVANCE), .BURST_ADDR(BURST_ADDR), .READY(READY), .BUSY(BUSY),
  .DONE_PULSE(DONE_PULSE), .ARRAY_DATA(ARRAY_DATA), .ARRAY_WRITE(ARRAY_WRITE));
`default_nettype wire

// *** dv/flash_host_model.sv ***
/* Host controller model issuing command write cycles.
   Assumes the shared MCLK; drives just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module flash_host_model
  import flash_seq_pkg::*;
(
  input wire logic MCLK,
  input wire logic BUSY,
  output logic WR_STROBE,
  output logic [ADDR_W-1:0] WR_ADDR,
  output logic [7:0] WR_DATA
);
  // Idle bus at time zero
  initial begin
    WR_STROBE = 1'b0;
    WR_ADDR = '0;
    WR_DATA = 8'h00;
  end
  // One write cycle; idle lines show the inverse so stale data never passes
  // Erase sequences are built from six, or in bypass two, of these single writes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge MCLK) #1;
    WR_STROBE = 1'b1;
    WR_ADDR = a;
    WR_DATA = d;
    @(posedge MCLK) #1;
    WR_STROBE = 1'b0;
    WR_ADDR = ~a;
    WR_DATA = ~d;
  endtask
  // Status poll: a plain level read, never through a burst; two reads must agree
  task automatic poll(output logic idle);
    logic first;
    @(posedge MCLK) #1;
    first = BUSY;
    @(posedge MCLK) #1;
    idle = !first && !BUSY;
  endtask
endmodule
`default_nettype wire

// *** dv/burst_flash_wait_and_embedded_ops_test.sv ***
/* Self-checking bench for flash_seq latency and erase.
   Assumes the host model owns the write port. */
`timescale 1ns/10ps
`default_nettype none
module burst_flash_wait_and_embedded_ops_test;
  import flash_seq_pkg::*;
  logic mclk, srst, bstart, badv, accel, wr_stb, ready, busy, done, awr;
  logic [ADDR_W-1:0] baddr, wr_addr;
  logic [7:0] wr_data;
  logic [DATA_W-1:0] adata;
  int err_total, num_checks;
  // Shortened timing so a whole erase fits in a few dozen cycles
  localparam int REGION_W = 4;
  localparam int PROG_C = 3;
  localparam int PROG_ACC_C = 2;
  localparam int ERASE_C = 10;
  flash_seq #(.REGION_WORDS(REGION_W), .ERASE_CYCLES(ERASE_C), .PROG_CYCLES(PROG_C),
    .PROG_ACC_CYCLES(PROG_ACC_C)) dut (.MCLK(mclk),
    .SRST(srst), .WR_STROBE(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BURST_START(bstart),
    .BURST_ADVANCE(badv), .BURST_ADDR(baddr), .ACCEL_PIN(accel), .READY(ready), .BUSY(busy),
    .DONE_PULSE(done), .ARRAY_ADDR(), .ARRAY_DATA(adata), .ARRAY_WRITE(awr));
  flash_host_model host (.MCLK(mclk), .BUSY(busy), .WR_STROBE(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  ////////////////////////////////
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One start or advance pulse; counts the cycles READY stays low
  task automatic burst(input logic st, input logic [ADDR_W-1:0] a, output int n);
    logic rdy;
    @(posedge mclk) #1;
    bstart = st;
    badv = !st;
    baddr = a;
    n = 0;
    do begin
      #1;
      rdy = ready;
      if (rdy !== 1'b1) n++;
      @(posedge mclk) #1;
      bstart = 1'b0;
      badv = 1'b0;
    end while (rdy !== 1'b1 && n < 20);
  endtask
  ////////////////////////////////
  task automatic t_wait;
    int n;
    for (int w = 0; w < 4; w++) begin
      host.wr(ADDR_W'(w) << 12, CMD_CONFIG);
      burst(1'b1, 22'h00007e, n);
      chk(n, 4 + w);
    end
    $display("wait state test ended");
  endtask
  // Field kept from the last config; then boundary and plain advances
  task automatic t_bnd;
    int n;
    burst(1'b1, 22'h00007e, n);
    chk(n, 7);
    burst(1'b0, 22'h000080, n);
    chk(n, 3);
    burst(1'b0, 22'h000081, n);
    chk(n, 0);
    $display("boundary test ended");
  endtask
  // Mid-run reset drops the wait field back to zero
  task automatic t_rst;
    int n;
    @(posedge mclk) #1;
    srst = 1'b1;
    @(posedge mclk) #1;
    srst = 1'b0;
    chk(ready, 1'b1);
    chk(busy, 1'b0);
    burst(1'b1, 22'h00007e, n);
    chk(n, BASE_LATENCY);
    $display("reset test ended");
  endtask
  // Waits out one erase under a bound; counts zero writes and cycles to done
  task automatic erase_wait(input int exp_cyc);
    int wr_n;
    int cyc;
    logic idle;
    chk(busy, 1'b1);
    wr_n = 0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 500) begin
      @(posedge mclk) #2;
      cyc++;
      if (awr === 1'b1 && adata === ZERO_WORD) wr_n++;
    end
    chk(wr_n, REGION_W);
    chk(cyc, exp_cyc);
    chk(busy, 1'b0);
    host.poll(idle);
    chk(idle, 1'b1);
    $display("erase test ended");
  endtask
  // Full six-write chip erase with the supply low
  task automatic t_erase_norm;
    accel = 1'b0;
    host.wr('0, CMD_UNLOCK1);
    host.wr('0, CMD_UNLOCK2);
    host.wr('0, CMD_ERASE_SETUP);
    host.wr('0, CMD_UNLOCK1);
    host.wr('0, CMD_UNLOCK2);
    host.wr('0, CMD_CHIP_ERASE);
    erase_wait(REGION_W * PROG_C + ERASE_C + 1);
  endtask
  // Bypass entry, then the two-write erase with the supply raised
  task automatic t_erase_byp;
    // Supply raised before the unlock writes, so the synchroniser has settled by the erase
    accel = 1'b1;
    host.wr('0, CMD_UNLOCK1);
    host.wr('0, CMD_UNLOCK2);
    host.wr('0, CMD_BYPASS_ENTER);
    host.wr('0, CMD_ERASE_SETUP);
    host.wr('0, CMD_CHIP_ERASE);
    erase_wait(REGION_W * PROG_ACC_C + ERASE_C + 1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1;
    bstart = 1'b0;
    badv = 1'b0;
    baddr = '0;
    accel = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_wait;
    t_bnd;
    t_rst;
    t_erase_norm;
    t_erase_byp;
    test_done;
  end
  // Watchdog far beyond the expected run
  initial begin
    #20000;
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
